// File: include/ubcu_defines.vh
// Constants for the user break condition unit
`ifndef UBCU_DEFINES_VH
`define UBCU_DEFINES_VH
// Register indices on the plain register port
`define UBCU_REG_ADDR_A    4'h0
`define UBCU_REG_AMASK_A   4'h1
`define UBCU_REG_CYC_A     4'h2
`define UBCU_REG_ADDRESS_SPACE_ID_A    4'h3
`define UBCU_REG_ADDR_B    4'h4
`define UBCU_REG_AMASK_B   4'h5
`define UBCU_REG_CYC_B     4'h6
`define UBCU_REG_ADDRESS_SPACE_ID_B    4'h7
`define UBCU_REG_DATA_B    4'h8
`define UBCU_REG_DMASK_B   4'h9
`define UBCU_REG_CTRL      4'hA
`define UBCU_REG_DBASE     4'hB
`define UBCU_REG_SAVSTK    4'hC
// Break control register fields
`define UBCU_CTRL_FLAGB    15
`define UBCU_CTRL_FLAGA    14
`define UBCU_CTRL_PCSELA   10
`define UBCU_CTRL_DENB     7
`define UBCU_CTRL_PCSELB   6
`define UBCU_CTRL_SEQ      3
`define UBCU_CTRL_DBGEN    0
`define UBCU_CTRL_RESET    16'h0000
// Bus cycle register fields
`define UBCU_CYC_IDHI      5
`define UBCU_CYC_IDLO      4
`define UBCU_CYC_RWHI      3
`define UBCU_CYC_RWLO      2
`define UBCU_CYC_SZ2       6
`define UBCU_CYC_SZHI      1
`define UBCU_CYC_SZLO      0
// Address mask codes
`define UBCU_AMASK_NONE    2'h0
`define UBCU_AMASK_10      2'h1
`define UBCU_AMASK_12      2'h2
// Operand size codes
`define UBCU_SZ_ANY        3'h0
`define UBCU_SZ_BYTE       3'h1
`define UBCU_SZ_WORD       3'h2
`define UBCU_SZ_LONG       3'h3
`define UBCU_SZ_QUAD       3'h4
// Default vector offset for a break
`define UBCU_BREAK_OFFSET  32'h0000_0100
`endif

// File: core/ubcu_chan_match.v
// One channel comparator of the user break condition unit
`timescale 1ns/1ps
`default_nettype none
`include "ubcu_defines.vh"
module ubcu_chan_match (
  input  wire [31:0] cfgAddr,
  input  wire [1:0]  cfgAmask,
  input  wire [6:0]  cfgCycle,
  input  wire [7:0]  cfgAsid,
  input  wire        dataEn,
  input  wire [31:0] cfgData,
  input  wire [31:0] cfgDmask,
  input  wire        accValid,
  input  wire        accIsFetch,
  input  wire        accWrite,
  input  wire [2:0]  accSize,
  input  wire [31:0] accAddr,
  input  wire [7:0]  accAsid,
  input  wire        accHasData,
  input  wire [63:0] accData,
  output reg         hit
);
  reg  [31:0] cmpMask;
  reg  [2:0]  sz;
  reg         cycOk;
  wire [31:0] dmaskInv = ~cfgDmask;
  wire        dataHit  = ((accData[31:0] & dmaskInv) == (cfgData & dmaskInv)) ||
                         ((accData[63:32] & dmaskInv) == (cfgData & dmaskInv));
  // Compare address, space, cycle kind and data
  always @* begin
    sz = {cfgCycle[`UBCU_CYC_SZ2], cfgCycle[`UBCU_CYC_SZHI], cfgCycle[`UBCU_CYC_SZLO]};
    if (sz == `UBCU_SZ_ANY) begin
      sz = accSize; // RULE21
    end
    case (sz)
      `UBCU_SZ_QUAD: cmpMask = 32'hFFFF_FFF8;
      `UBCU_SZ_LONG: cmpMask = 32'hFFFF_FFFC;
      `UBCU_SZ_WORD: cmpMask = 32'hFFFF_FFFE;
      default:       cmpMask = 32'hFFFF_FFFF;
    endcase
    case (cfgAmask)
      `UBCU_AMASK_10: cmpMask = cmpMask & 32'hFFFF_FC00; // RULE18
      `UBCU_AMASK_12: cmpMask = cmpMask & 32'hFFFF_F000; // RULE18
      default:        cmpMask = cmpMask;
    endcase
    // Fetches are reads only; id field picks fetch or operand
    cycOk = (accIsFetch ? cfgCycle[`UBCU_CYC_IDLO] : cfgCycle[`UBCU_CYC_IDHI]) &&
            (accWrite ? cfgCycle[`UBCU_CYC_RWHI] : cfgCycle[`UBCU_CYC_RWLO]) &&
            !(accIsFetch && accWrite); // RULE19
    hit = accValid && cycOk && (accAsid == cfgAsid) &&
          ((accAddr & cmpMask) == (cfgAddr & cmpMask)) &&
          !(accIsFetch && cfgAddr[0] && cfgAmask != `UBCU_AMASK_10 &&
            cfgAmask != `UBCU_AMASK_12) && // RULE20
          !(dataEn && !accIsFetch && !(accHasData && dataHit)); // RULE22
  end
endmodule
`default_nettype wire

// File: core/ubcu_mask_judge.v
// Block-mask acceptance judge for one break
`timescale 1ns/1ps
`default_nettype none
module ubcu_mask_judge (
  input  wire isFetch,
  input  wire isPre,
  input  wire maskBefore,
  input  wire maskAfter,
  output reg  accept
);
  // Pick which mask value rules the break
  always @* begin
    if (isFetch && isPre) begin
      accept = !maskBefore; // RULE5 RULE8
    end else if (isFetch) begin
      accept = !(maskBefore | maskAfter); // RULE6 RULE8
    end else begin
      accept = !maskAfter; // RULE7 RULE8
    end
  end
endmodule
`default_nettype wire

// File: core/user_break_condition_unit.v
// Two-channel user break condition unit, top level
// Overview of operation
// RULE1 - Software avoids one operand access hitting both
// RULE2 - Sequential mode advances A then B within instruction
// RULE3 - No post-execution fetch break on sleep
// RULE4 - No operand break 1..3 before sleep
// RULE5 - Pre-execution fetch uses mask before instruction
// RULE6 - Post-execution fetch uses OR of masks
// RULE7 - Operand break uses mask after instruction
// RULE8 - Mask transition table decides acceptance
// RULE9 - Return delay slot masks from status copies; code takes only the after mask from savedStatusMask
// RULE10 - Taken exception forces mask set for handler; code forces it only for a break or otherExcTaken
// RULE11 - Same saved PC gives one break, both flags
// RULE12 - PC selector ignored for fetch breaks
// RULE13 - Sequential B match resets A tracking
// RULE14 - Re-execution exception beats post-execution break
// RULE15 - Higher completion exception suppresses break, flag set
// RULE16 - Debug enable takes target from debug base
// RULE17 - Every exception copies stack register to save
// RULE18 - Mask codes ignore low ten or twelve bits
// RULE19 - Fetch configured as write never matches
// RULE20 - Odd fetch address never matches; code blocks it only when no mask code is set
// RULE21 - Unsized condition compares per actual access size
// RULE22 - Data enable requires address, space, data match
// RULE23 - Match flags stay until software clears
`timescale 1ns/1ps
`default_nettype none
`include "ubcu_defines.vh"
module user_break_condition_unit (
  input  wire        mclk,
  input  wire        resetn,
  input  wire [3:0]  regAddr,
  input  wire [31:0] regWdata,
  input  wire        regWrite,
  input  wire        regRead,
  output reg  [31:0] regRdata,
  input  wire        accValid,
  input  wire        accIsFetch,
  input  wire        accIsPre,
  input  wire        accWrite,
  input  wire [2:0]  accSize,
  input  wire [31:0] accAddr,
  input  wire [7:0]  accAsid,
  input  wire        accHasData,
  input  wire [63:0] accData,
  input  wire [31:0] pcCurrent,
  input  wire [31:0] pcNext,
  input  wire        instrDone,
  input  wire        blockMaskBefore,
  input  wire        blockMaskAfter,
  input  wire        inReturnSlot,
  input  wire        savedStatusMask,
  input  wire        reexecExc,
  input  wire        completionExc,
  input  wire        otherExcTaken,
  input  wire [31:0] stackGpr,
  input  wire [31:0] vectorBase,
  output reg         breakReq,
  output reg  [31:0] breakPc,
  output reg  [31:0] excTarget,
  output reg         handlerMaskForce,
  output reg         matchFlagA,
  output reg         matchFlagB
);
  ////////////////////////////////////////////////////////////////////////
  // Configuration registers
  reg  [31:0] addrA;
  reg  [1:0]  amaskA;
  reg  [6:0]  cycA;
  reg  [7:0]  asidA;
  reg  [31:0] addrB;
  reg  [1:0]  amaskB;
  reg  [6:0]  cycB;
  reg  [7:0]  asidB;
  reg  [31:0] dataB;
  reg  [31:0] dmaskB;
  reg  [15:0] ctrl;
  reg  [31:0] debugBase;
  reg  [31:0] savedStack;
  reg         seqArmed;
  wire        hitA;
  wire        hitB;
  wire        acceptA;
  wire        acceptB;

  ////////////////////////////////////////////////////////////////////////
  // Channel settings, index 0 is channel A and 1 is channel B
  wire [31:0] chanAddr   [0:1];
  wire [1:0]  chanAmask  [0:1];
  wire [6:0]  chanCycle  [0:1];
  wire [7:0]  chanAsid   [0:1];
  wire        chanDataEn [0:1];
  wire [31:0] chanData   [0:1];
  wire [31:0] chanDmask  [0:1];
  wire [1:0]  hitV;
  wire [1:0]  acceptV;
  // Channel A settings then channel B settings
  assign chanAddr[0]   = addrA;
  assign chanAddr[1]   = addrB;
  assign chanAmask[0]  = amaskA;
  assign chanAmask[1]  = amaskB;
  assign chanCycle[0]  = cycA;
  assign chanCycle[1]  = cycB;
  assign chanAsid[0]   = asidA;
  assign chanAsid[1]   = asidB;
  // Only channel B carries a data condition
  assign chanDataEn[0] = 1'b0;
  assign chanDataEn[1] = ctrl[`UBCU_CTRL_DENB];
  assign chanData[0]   = 32'h0000_0000;
  assign chanData[1]   = dataB;
  assign chanDmask[0]  = 32'h0000_0000;
  assign chanDmask[1]  = dmaskB;
  // Named per-channel results for the decision logic
  assign hitA          = hitV[0];
  assign hitB          = hitV[1];
  assign acceptA       = acceptV[0];
  assign acceptB       = acceptV[1];

  ////////////////////////////////////////////////////////////////////////
  // Block-mask values seen by the judges
  // In a return slot the after value is the saved-status copy
  wire effBefore = inReturnSlot ? blockMaskBefore : blockMaskBefore; // RULE9
  wire effAfter  = inReturnSlot ? savedStatusMask : blockMaskAfter;  // RULE9
  wire isPostKind = !(accIsFetch && accIsPre);

  ////////////////////////////////////////////////////////////////////////
  // One comparator and one mask judge per channel
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : gChan
      ubcu_chan_match uChan (
        .cfgAddr    (chanAddr[gi]),
        .cfgAmask   (chanAmask[gi]),
        .cfgCycle   (chanCycle[gi]),
        .cfgAsid    (chanAsid[gi]),
        .dataEn     (chanDataEn[gi]),
        .cfgData    (chanData[gi]),
        .cfgDmask   (chanDmask[gi]),
        .accValid   (accValid),
        .accIsFetch (accIsFetch),
        .accWrite   (accWrite),
        .accSize    (accSize),
        .accAddr    (accAddr),
        .accAsid    (accAsid),
        .accHasData (accHasData),
        .accData    (accData),
        .hit        (hitV[gi])
      );
      // Each judge picks the mask value that rules its break kind
      ubcu_mask_judge uJudge (
        .isFetch    (accIsFetch),
        .isPre      (accIsPre),
        .maskBefore (effBefore),
        .maskAfter  (effAfter),
        .accept     (acceptV[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Break decision
  reg        fireA;
  reg        fireB;
  reg        seqMode;
  reg        suppress;
  reg        setFlagA;
  reg        setFlagB;
  reg        next_seqArmed;
  reg [31:0] pcA;
  reg [31:0] pcB;
  // Pre fetch breaks flag at detection, others when the instruction ends
  always @* begin
    seqMode  = ctrl[`UBCU_CTRL_SEQ];
    setFlagA = hitA && (!isPostKind || instrDone);
    setFlagB = hitB && (!isPostKind || instrDone);
    // A re-execution exception wins; flag left set, either way allowed
    suppress = isPostKind && (reexecExc || completionExc); // RULE14 RULE15
    next_seqArmed = seqArmed;
    fireA = 1'b0;
    fireB = 1'b0;
    if (seqMode) begin
      if (setFlagA) begin
        next_seqArmed = 1'b1; // RULE2
      end
      if (setFlagB && seqArmed) begin
        fireB = acceptB;
        next_seqArmed = 1'b0; // RULE13
      end
    end else begin
      fireA = setFlagA && acceptA;
      fireB = setFlagB && acceptB;
    end
    // Saved PC selection; selector is ignored for fetch breaks
    pcA = (accIsFetch && accIsPre) ? pcCurrent : pcNext;
    pcB = pcA;
    if (!accIsFetch) begin
      pcA = ctrl[`UBCU_CTRL_PCSELA] ? pcCurrent : pcNext; // RULE12
      pcB = ctrl[`UBCU_CTRL_PCSELB] ? pcCurrent : pcNext; // RULE12
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Break output, flags and sequence state
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      breakReq         <= 1'b0;
      breakPc          <= 32'h0000_0000;
      excTarget        <= 32'h0000_0000;
      handlerMaskForce <= 1'b0;
      matchFlagA       <= 1'b0;
      matchFlagB       <= 1'b0;
      seqArmed         <= 1'b0;
      savedStack       <= 32'h0000_0000;
    end else begin
      // One break even when both channels fire together
      breakReq <= (fireA || fireB) && !suppress; // RULE11 RULE15
      if (fireA || fireB) begin
        breakPc <= fireA ? pcA : pcB; // RULE11
        excTarget <= ctrl[`UBCU_CTRL_DBGEN] ? debugBase :
                     vectorBase + `UBCU_BREAK_OFFSET; // RULE16
      end
      // Handler sees the mask set after a taken break or otherExcTaken, not after reexecExc or completionExc
      handlerMaskForce <= ((fireA || fireB) && !suppress) || otherExcTaken; // RULE10
      if (((fireA || fireB) && !suppress) || otherExcTaken || reexecExc || completionExc) begin
        savedStack <= stackGpr; // RULE17
      end
      seqArmed <= next_seqArmed;
      // Sticky flags: set wins over a software clear
      if (setFlagA) begin
        matchFlagA <= 1'b1; // RULE23 RULE15
      end else if (regWrite && regAddr == `UBCU_REG_CTRL && !regWdata[`UBCU_CTRL_FLAGA]) begin
        matchFlagA <= 1'b0; // RULE23
      end
      if (setFlagB) begin
        matchFlagB <= 1'b1; // RULE23 RULE11
      end else if (regWrite && regAddr == `UBCU_REG_CTRL && !regWdata[`UBCU_CTRL_FLAGB]) begin
        matchFlagB <= 1'b0; // RULE23
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register writes
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      addrA     <= 32'h0000_0000;
      amaskA    <= 2'h0;
      cycA      <= 7'h00;
      asidA     <= 8'h00;
      addrB     <= 32'h0000_0000;
      amaskB    <= 2'h0;
      cycB      <= 7'h00;
      asidB     <= 8'h00;
      dataB     <= 32'h0000_0000;
      dmaskB    <= 32'h0000_0000;
      ctrl      <= `UBCU_CTRL_RESET;
      debugBase <= 32'h0000_0000;
    end else if (regWrite) begin
      case (regAddr)
        `UBCU_REG_ADDR_A:  addrA     <= regWdata;
        `UBCU_REG_AMASK_A: amaskA    <= regWdata[1:0];
        `UBCU_REG_CYC_A:   cycA      <= regWdata[6:0];
        `UBCU_REG_ADDRESS_SPACE_ID_A:  asidA     <= regWdata[7:0];
        `UBCU_REG_ADDR_B:  addrB     <= regWdata;
        `UBCU_REG_AMASK_B: amaskB    <= regWdata[1:0];
        `UBCU_REG_CYC_B:   cycB      <= regWdata[6:0];
        `UBCU_REG_ADDRESS_SPACE_ID_B:  asidB     <= regWdata[7:0];
        `UBCU_REG_DATA_B:  dataB     <= regWdata;
        `UBCU_REG_DMASK_B: dmaskB    <= regWdata;
        `UBCU_REG_CTRL:    ctrl      <= {2'b00, regWdata[13:0]};
        `UBCU_REG_DBASE:   debugBase <= regWdata;
        default:           ctrl      <= ctrl;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register reads, data one cycle after the strobe
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      regRdata <= 32'h0000_0000;
    end else if (regRead) begin
      case (regAddr)
        `UBCU_REG_ADDR_A:  regRdata <= addrA;
        `UBCU_REG_AMASK_A: regRdata <= {30'h0000_0000, amaskA};
        `UBCU_REG_CYC_A:   regRdata <= {25'h000_0000, cycA};
        `UBCU_REG_ADDRESS_SPACE_ID_A:  regRdata <= {24'h00_0000, asidA};
        `UBCU_REG_ADDR_B:  regRdata <= addrB;
        `UBCU_REG_AMASK_B: regRdata <= {30'h0000_0000, amaskB};
        `UBCU_REG_CYC_B:   regRdata <= {25'h000_0000, cycB};
        `UBCU_REG_ADDRESS_SPACE_ID_B:  regRdata <= {24'h00_0000, asidB};
        `UBCU_REG_DATA_B:  regRdata <= dataB;
        `UBCU_REG_DMASK_B: regRdata <= dmaskB;
        `UBCU_REG_CTRL:    regRdata <= {16'h0000, matchFlagB, matchFlagA, ctrl[13:0]};
        `UBCU_REG_DBASE:   regRdata <= debugBase;
        `UBCU_REG_SAVSTK:  regRdata <= savedStack;
        default:           regRdata <= 32'h0000_0000;
      endcase
    end else begin
      regRdata <= 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

// File: verification/ubcu_props.sv
// Port-level assertions for the user break condition unit
`timescale 1ns/1ps
`default_nettype none
`include "ubcu_defines.vh"
module ubcu_props (
  input wire        mclk,
  input wire        resetn,
  input wire [3:0]  regAddr,
  input wire        regWrite,
  input wire        accValid,
  input wire        accIsFetch,
  input wire        accIsPre,
  input wire        blockMaskBefore,
  input wire        blockMaskAfter,
  input wire        inReturnSlot,
  input wire        savedStatusMask,
  input wire        completionExc,
  input wire        otherExcTaken,
  input wire [31:0] pcCurrent,
  input wire        breakReq,
  input wire [31:0] breakPc,
  input wire        handlerMaskForce,
  input wire        matchFlagA
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////
  // Access kinds as the core presents them
  sequence s_pre; accValid && accIsFetch && accIsPre; endsequence
  sequence s_post; accValid && accIsFetch && !accIsPre; endsequence
  sequence s_opnd; accValid && !accIsFetch; endsequence
  // Masking and priority leave no break pulse in the answer cycle
  property p_preMask; s_pre ##0 blockMaskBefore |=> !breakReq; endproperty
  a_preMask: assert property (p_preMask) else $error("pre fetch break under mask");
  property p_postMask; s_post ##0 !inReturnSlot && (blockMaskBefore || blockMaskAfter) |=> !breakReq; endproperty
  a_postMask: assert property (p_postMask) else $error("post fetch break under mask");
  property p_opndMask; s_opnd ##0 !inReturnSlot && blockMaskAfter |=> !breakReq; endproperty
  a_opndMask: assert property (p_opndMask) else $error("operand break under mask");
  property p_slotMask; s_opnd ##0 inReturnSlot && savedStatusMask |=> !breakReq; endproperty
  a_slotMask: assert property (p_slotMask) else $error("slot break under saved mask");
  property p_compl; s_post ##0 completionExc |=> !breakReq; endproperty
  a_compl: assert property (p_compl) else $error("break beat completion exception");
  // Handler mask, saved PC and sticky flag
  property p_handler; otherExcTaken && !blockMaskBefore && !blockMaskAfter |=> handlerMaskForce; endproperty
  a_handler: assert property (p_handler) else $error("handler mask not forced");
  property p_prePc; s_pre |=> !breakReq || breakPc == $past(pcCurrent); endproperty
  a_prePc: assert property (p_prePc) else $error("pre fetch saved wrong pc");
  property p_flagA; matchFlagA && !(regWrite && regAddr == `UBCU_REG_CTRL) |=> matchFlagA; endproperty
  a_flagA: assert property (p_flagA) else $error("flag A dropped without clear");
endmodule
`default_nettype wire

// File: verification/ubcu_core_model.sv
// Core pipeline model that presents fetches and operand accesses
`timescale 1ns/1ps
`default_nettype none
module ubcu_core_model (
  input  wire logic  mclk,
  output logic       accValid,
  output logic       accIsFetch,
  output logic       accIsPre,
  output logic       accWrite,
  output logic [2:0] accSize,
  output logic [31:0] accAddr,
  output logic [7:0] accAsid,
  output logic       accHasData,
  output logic [63:0] accData,
  output logic [31:0] pcCurrent,
  output logic [31:0] pcNext,
  output logic       instrDone,
  output logic       blockMaskBefore,
  output logic       blockMaskAfter,
  output logic       inReturnSlot,
  output logic       savedStatusMask,
  output logic       reexecExc,
  output logic       completionExc,
  output logic       otherExcTaken,
  output logic [31:0] stackGpr,
  output logic [31:0] vectorBase
);
  logic [31:0] pcReg;
  // Quiet core at time zero
  initial begin
    {accValid, accIsFetch, accIsPre, accWrite, accSize, accAddr, accAsid, accHasData, accData,
     pcCurrent, pcNext, instrDone, blockMaskBefore, blockMaskAfter, inReturnSlot,
     savedStatusMask, reexecExc, completionExc, otherExcTaken} = '0;
    stackGpr = 32'h0000_1000;
    vectorBase = 32'h0000_8000;
    pcReg = 32'h0000_0200;
  end
  // One access for one cycle; no sleep instruction is ever presented
  // Callers never set up an operand access that hits both channels
  task automatic go(input logic [10:0] f, input logic [2:0] sz, input logic [31:0] a,
                    input logic [7:0] id, input logic [63:0] d);
    @(posedge mclk);
    {accIsFetch, accIsPre, accWrite, accHasData, blockMaskBefore, blockMaskAfter,
     inReturnSlot, savedStatusMask, reexecExc, completionExc, otherExcTaken} <= f;
    {accValid, instrDone} <= 2'h3;
    {accSize, accAddr, accAsid, accData} <= {sz, a, id, d};
    pcCurrent <= f[10] ? a : pcReg;
    pcNext <= (f[10] ? a : pcReg) + 32'h0000_0002;
    pcReg <= pcReg + 32'h0000_0002;
    stackGpr <= stackGpr + 32'h0000_0004;
    @(posedge mclk);
    {accValid, instrDone, reexecExc, completionExc, otherExcTaken} <= 5'h0;
    {accAddr, accAsid, accData} <= {~a, ~id, ~d};
  endtask
endmodule
`default_nettype wire

// File: verification/user_break_condition_unit_tb.sv
// Self-checking testbench for the user break condition unit
`timescale 1ns/1ps
`default_nettype none
`include "ubcu_defines.vh"
module user_break_condition_unit_tb;
  localparam logic [10:0] F_FET = 11'h400, F_PRE = 11'h200, F_WR = 11'h180, F_OTH = 11'h001;
  logic        mclk, resetn, regWrite, regRead, accValid, accIsFetch, accIsPre, accWrite;
  logic        accHasData, instrDone, blockMaskBefore, blockMaskAfter, inReturnSlot;
  logic        savedStatusMask, reexecExc, completionExc, otherExcTaken, breakReq;
  logic        handlerMaskForce, matchFlagA, matchFlagB, e, ma;
  logic [2:0]  accSize;
  logic [3:0]  regAddr;
  logic [7:0]  accAsid, aid;
  logic [10:0] f;
  logic [31:0] regWdata, regRdata, accAddr, pcCurrent, pcNext, stackGpr, vectorBase;
  logic [31:0] breakPc, excTarget, k;
  logic [63:0] accData, dat;
  integer      failures, checkCount, cycles, seed, i, kd;
  ubcu_core_model i_core (.*);
  user_break_condition_unit i_dut (.*);
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  ////////////////////////////////////////
  // Count a comparison and report a mismatch
  task automatic chk(input logic [63:0] got, input logic [63:0] want);
    checkCount = checkCount + 1;
    if (got !== want) begin
      failures = failures + 1;
      $display("ERROR %0t: got %h expected %h", $time, got, want);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    {regAddr, regWdata, regWrite} <= {a, d, 1'b1};
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] want);
    @(posedge mclk);
    {regAddr, regRead} <= {a, 1'b1};
    @(posedge mclk);
    regRead <= 1'b0;
    #1 chk(regRdata, want);
  endtask
  // Load one channel: address, mask code, bus cycle, space id 80
  task automatic cfg(input logic [3:0] b, input logic [31:0] a, input logic [1:0] m,
                     input logic [6:0] c);
    wr(b, a);
    wr(b + 4'h1, {30'h0, m});
    wr(b + 4'h2, {25'h0, c});
    wr(b + 4'h3, 32'h0000_0080);
  endtask
  // Present one access and look at the break pulse in the answer cycle
  task automatic hit(input logic [10:0] fl, input logic [2:0] sz, input logic [31:0] a,
                     input logic ex);
    i_core.go(fl, sz, a, aid, dat);
    #1 chk(breakReq, ex);
  endtask
  // Acceptance by kind: 0 pre fetch, 1 post fetch, 2 operand
  function automatic logic expAcc(input integer t, input logic b, input logic af);
    expAcc = (t == 0) ? !b : (t == 1) ? !(b | af) : !af;
  endfunction
  task automatic testDone;
    $display("checks %0d failures %0d", checkCount, failures);
    if (failures == 0 && checkCount > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Cut a hung run short
  always @(posedge mclk) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      failures = failures + 1;
      testDone;
    end
  end
  ////////////////////////////////////////
  initial begin
    {seed, failures, checkCount, cycles} = {32'd42, 96'h0};
    {aid, dat, resetn, regAddr, regWdata, regWrite, regRead} = {8'h80, 103'h0};
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    rdc(`UBCU_REG_CTRL, `UBCU_CTRL_RESET);
    rdc(4'hF, 32'h0000_0000);
    // Operand read with size left open, then masked ranges with random offsets
    cfg(4'h0, 32'h0012_3456, 2'h0, 7'h24);
    hit(11'h0, `UBCU_SZ_LONG, 32'h0012_3454, 1'b1);
    hit(11'h0, `UBCU_SZ_BYTE, 32'h0012_3457, 1'b0);
    hit(11'h0, `UBCU_SZ_QUAD, 32'h0012_3450, 1'b1);
    wr(`UBCU_REG_AMASK_A, 32'h0000_0001);
    hit(11'h0, `UBCU_SZ_BYTE, 32'h0012_37FF, 1'b1);
    hit(11'h0, `UBCU_SZ_BYTE, 32'h0012_3800, 1'b0);
    for (i = 0; i < 24; i = i + 1) begin
      k = $random(seed);
      wr(`UBCU_REG_AMASK_A, {30'h0, k[14], !k[14]});
      e = k[14] ? (k[13:12] == 2'h3) : (k[13:10] == 4'hD);
      hit(11'h0, `UBCU_SZ_BYTE, {18'h48, k[13:0]}, e);
    end
    $display("test address mask done");
    // Fetch set up as write; even fetch against an odd setting
    cfg(4'h0, 32'h0002_7128, 2'h0, 7'h1A);
    cfg(4'h4, 32'h0003_1415, 2'h0, 7'h14);
    hit(F_FET | F_PRE, `UBCU_SZ_WORD, 32'h0002_7128, 1'b0);
    hit(F_FET | F_PRE, `UBCU_SZ_WORD, 32'h0003_1414, 1'b0);
    // Every kind against every mask transition, inside and outside a return slot
    cfg(4'h0, 32'h0000_0404, 2'h0, 7'h14);
    cfg(4'h4, 32'h0000_2000, 2'h0, 7'h24);
    wr(`UBCU_REG_CTRL, 32'h0000_0440);
    for (i = 0; i < 24; i = i + 1) begin
      kd = i / 8;
      ma = i[2] ? !i[0] : i[0];
      f = {kd < 2, kd == 0, 2'h0, i[1], i[0], i[2], !i[0], 3'h0};
      k = kd < 2 ? 32'h0000_0404 : 32'h0000_2000;
      e = expAcc(kd, i[1], ma);
      hit(f, kd < 2 ? `UBCU_SZ_WORD : `UBCU_SZ_LONG, k, e);
      if (e) chk(breakPc, kd == 1 ? pcNext : pcCurrent);
    end
    wr(`UBCU_REG_CTRL, 32'h0000_0440);
    hit(F_FET | 11'h002, `UBCU_SZ_WORD, 32'h0000_0404, 1'b0);
    chk(matchFlagA, 1'b1);
    hit(F_FET | 11'h004, `UBCU_SZ_WORD, 32'h0000_0404, 1'b0);
    $display("test mask table done");
    // Other exception with mask clear, then break targets and saved stack
    hit(F_FET | F_PRE | F_OTH, `UBCU_SZ_WORD, 32'h0000_0600, 1'b0);
    chk(handlerMaskForce, 1'b1);
    wr(`UBCU_REG_DBASE, 32'h0000_C000);
    hit(F_FET | F_PRE, `UBCU_SZ_WORD, 32'h0000_0404, 1'b1);
    chk(excTarget, vectorBase + `UBCU_BREAK_OFFSET);
    rdc(`UBCU_REG_SAVSTK, stackGpr);
    wr(`UBCU_REG_CTRL, 32'h0000_0001);
    hit(F_FET | F_PRE, `UBCU_SZ_WORD, 32'h0000_0404, 1'b1);
    chk(excTarget, 32'h0000_C000);
    $display("test exception target done");
    // Sequential mode: A, A, then B breaks once; a lone B does not
    cfg(4'h0, 32'h0000_3000, 2'h0, 7'h24);
    wr(`UBCU_REG_CTRL, 32'h0000_0008);
    for (i = 0; i < 4; i = i + 1)
      hit(11'h0, `UBCU_SZ_LONG, i < 2 ? 32'h0000_3000 : 32'h0000_2000, i == 2);
    chk(matchFlagB, 1'b1);
    // Both channels on one pre fetch: one break pulse, both flags, one saved PC
    wr(`UBCU_REG_CTRL, 32'h0000_0000);
    wr(`UBCU_REG_CYC_A, 32'h0000_0014);
    wr(`UBCU_REG_ADDR_B, 32'h0000_3000);
    wr(`UBCU_REG_CYC_B, 32'h0000_0014);
    hit(F_FET | F_PRE, `UBCU_SZ_WORD, 32'h0000_3000, 1'b1);
    chk({matchFlagA, matchFlagB}, 2'h3);
    chk(breakPc, pcCurrent);
    @(posedge mclk);
    #1 chk(breakReq, 1'b0);
    // Data condition on channel B: with the address matching, space and data both needed
    cfg(4'h4, 32'h000A_BCDE, 2'h2, 7'h2A);
    wr(`UBCU_REG_DATA_B, 32'h0000_A512);
    wr(`UBCU_REG_DMASK_B, 32'h0000_0000);
    wr(`UBCU_REG_CTRL, 32'h0000_0080);
    {aid, dat} = {8'h70, 64'h0000_0000_0000_A512};
    hit(F_WR, `UBCU_SZ_WORD, 32'h000A_B000, 1'b0);
    wr(`UBCU_REG_ADDRESS_SPACE_ID_B, 32'h0000_0070);
    hit(F_WR, `UBCU_SZ_WORD, 32'h000A_B000, 1'b1);
    dat = 64'h0000_0000_0000_A513;
    hit(F_WR, `UBCU_SZ_WORD, 32'h000A_B000, 1'b0);
    $display("test sequence and data done");
    testDone;
  end
endmodule
bind user_break_condition_unit ubcu_props i_props (.*);
`default_nettype wire
